/* File: core/dsd_top.sv */
// data-space address decoder, access sequencer and program word pointer
// Operation
// - program storage is 1024 words of 16 bits, 2K bytes.
// - program word pointer is 10 bits and starts at word zero.
// - program image appears in data space from 0x4000 to 0x47FF.
// - data-space writes to the program image change nothing.
// - lowest 64 data addresses are the I/O space.
// - next 128 addresses, 0x0040 to 0x00BF, go to data sram.
// - lock bits and flash are visible in data space, read-only.
// - direct, indirect, pre-decrement and post-increment modes; X, Y, Z pointers.
// - pre-decrement before the access, post-increment after it.
// - short I/O access reaches all 64 locations by 6-bit address.
// - direct load and store reach only the 128 sram locations.
// - pointer access reaches every location of data space.
// - each sram access completes in two core clock cycles.
// - pointer load and store read and write every I/O register.
// - bit set, clear and skip only for I/O addresses 0x00 to 0x1F.
// - some I/O status flags clear when a one is written; the i/o model stores written bits as given.
// - bit set and clear touch only the addressed bit.
// - registers and sram run on the core clock; halted clock halts all.
`timescale 1ns/1ps
`default_nettype none
module dsd_top
    import dsd_pkg::*;
#(
    parameter int PROG_WORDS = dsd_pkg::DSD_PROG_WORDS,
    parameter int SRAM_DEPTH = dsd_pkg::DSD_SRAM_DEPTH
) (
    // core clock and reset
    input wire logic clk,
    input wire logic rst,
    // access request from the core
    input wire logic req_valid,
    output logic req_ready,
    input wire dsd_pkg::dsd_op_e req_op,
    input wire logic [15:0] req_addr,
    input wire dsd_pkg::dsd_ptr_e req_ptr_sel,
    input wire dsd_pkg::dsd_mode_e req_ptr_mode,
    input wire logic [2:0] req_bit,
    input wire logic [7:0] req_wdata,
    // access answer
    output logic ack,
    output logic [7:0] rdata,
    output logic skip,
    // pointer pairs
    input wire logic ptr_wr_en,
    input wire dsd_pkg::dsd_ptr_e ptr_wr_sel,
    input wire logic [15:0] ptr_wr_data,
    output logic [15:0] ptr_x,
    output logic [15:0] ptr_y,
    output logic [15:0] ptr_z,
    // i/o register space
    output logic io_rd,
    output logic io_wr,
    output logic [5:0] io_addr,
    output logic [7:0] io_wdata,
    output logic [7:0] io_wmask,
    input wire logic [7:0] io_rdata,
    // nonvolatile lock bits
    input wire logic [7:0] lock_bits,
    // instruction fetch
    input wire logic fetch_step,
    input wire logic fetch_jump,
    input wire logic [9:0] fetch_target,
    output logic [9:0] program_word_pointer,
    output logic [15:0] instr_word,
    // external flash programming
    input wire logic ext_prog_en,
    input wire logic [9:0] ext_prog_addr,
    input wire logic [15:0] ext_prog_data
);
    import dsd_pkg::*;

    typedef struct packed {
        dsd_state_e st;
        dsd_op_e op;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] wmask;
        logic [2:0] bitn;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
        logic ack;
        logic [7:0] rdata;
        logic skip;
        logic [9:0] pwp;
        logic [15:0] instr;
    } dsd_top_s;

    localparam dsd_top_s RESET_S = '{
        st: DSD_ST_IDLE, op: DSD_OP_IO_IN, addr: 16'h0000, wdata: 8'h00,
        wmask: 8'h00, bitn: 3'h0, x: DSD_PTR_RESET, y: DSD_PTR_RESET,
        z: DSD_PTR_RESET, ack: 1'b0, rdata: 8'h00, skip: 1'b0,
        pwp: DSD_PWP_RESET, instr: 16'h0000
    };

    dsd_top_s s_r;
    dsd_top_s s_nxt;

    logic exec;
    logic is_write;
    logic is_bitop;
    logic in_io;
    logic in_sram;
    logic in_lock;
    logic in_flash;
    logic sram_we;
    logic [7:0] sram_rdata;
    logic [15:0] flash_word;
    logic [15:0] fetch_word;
    logic [15:0] cur_ptr;
    logic [6:0] sram_idx;
    logic [16:0] sram_off;

    function automatic logic [15:0] ptr_of(input dsd_top_s s, input dsd_ptr_e sel);
        case (sel)
            DSD_PTR_X: ptr_of = s.x;
            DSD_PTR_Y: ptr_of = s.y;
            DSD_PTR_Z: ptr_of = s.z;
            default: ptr_of = s.x;
        endcase
    endfunction

    // decode of the captured address
    assign exec = (s_r.st == DSD_ST_EXEC);
    assign is_write = (s_r.op == DSD_OP_IO_OUT) || (s_r.op == DSD_OP_DIRECT_STORE) ||
        (s_r.op == DSD_OP_POINTER_STORE) || (s_r.op == DSD_OP_IO_BIT_SET) ||
        (s_r.op == DSD_OP_IO_BIT_CLEAR);
    assign is_bitop = (s_r.op == DSD_OP_IO_BIT_SET) || (s_r.op == DSD_OP_IO_BIT_CLEAR);
    assign in_io = (s_r.addr <= DSD_IO_LAST);
    assign in_sram = (s_r.addr >= DSD_SRAM_BASE) && (s_r.addr <= DSD_SRAM_LAST);
    assign in_lock = (s_r.addr == DSD_LOCK_ADDR);
    assign in_flash = (s_r.addr >= DSD_FLASH_BASE) && (s_r.addr <= DSD_FLASH_LAST);
    assign sram_off = {1'b0, s_r.addr} - {1'b0, DSD_SRAM_BASE};
    assign sram_idx = sram_off[6:0];
    assign cur_ptr = ptr_of(s_r, req_ptr_sel);

    // flash and lock regions never see a write strobe
    assign sram_we = exec && is_write && in_sram;
    assign io_wr = exec && is_write && in_io;
    assign io_rd = exec && !is_write && in_io;
    assign io_addr = s_r.addr[5:0];
    assign io_wdata = s_r.wdata;
    assign io_wmask = s_r.wmask;

    dsd_sram #(
        .DEPTH(SRAM_DEPTH),
        .AW(DSD_SRAM_AW),
        .DW(DSD_DATA_W)
    ) u_sram (
        .clk(clk),
        .we(sram_we),
        .addr(sram_idx),
        .wdata(s_r.wdata),
        .rdata(sram_rdata)
    );

    dsd_prog_flash #(
        .WORDS(PROG_WORDS),
        .AW(DSD_PWP_W),
        .DW(DSD_PROG_W)
    ) u_flash (
        .clk(clk),
        .ext_prog_en(ext_prog_en),
        .ext_prog_addr(ext_prog_addr),
        .ext_prog_data(ext_prog_data),
        .fetch_addr(s_r.pwp),
        .fetch_data(fetch_word),
        .data_addr(s_r.addr[10:1]),
        .data_word(flash_word)
    );

    always_comb begin
        logic [15:0] p;
        logic [15:0] a;
        logic ok;
        logic [7:0] rd;
        p = 16'h0000;
        a = req_addr;
        ok = 1'b1;
        rd = 8'h00;
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        // pointer pairs written by the core's register file path
        if (ptr_wr_en) begin
            case (ptr_wr_sel)
                DSD_PTR_X: s_nxt.x = ptr_wr_data;
                DSD_PTR_Y: s_nxt.y = ptr_wr_data;
                DSD_PTR_Z: s_nxt.z = ptr_wr_data;
                default: s_nxt.x = ptr_wr_data;
            endcase
        end
        case (s_r.st)
            DSD_ST_IDLE: begin
                if (req_valid) begin
                    s_nxt.st = DSD_ST_EXEC;
                    s_nxt.op = req_op;
                    s_nxt.bitn = req_bit;
                    s_nxt.wdata = req_wdata;
                    s_nxt.wmask = 8'hFF;
                    case (req_op)
                        DSD_OP_IO_IN, DSD_OP_IO_OUT: begin
                            a = {10'h000, req_addr[5:0]};
                        end
                        DSD_OP_DIRECT_LOAD, DSD_OP_DIRECT_STORE: begin
                            // anything outside sram becomes a harmless unmapped access
                            ok = (req_addr >= DSD_SRAM_BASE) && (req_addr <= DSD_SRAM_LAST);
                            a = ok ? req_addr : DSD_FLASH_LAST + 16'h0001;
                        end
                        DSD_OP_POINTER_LOAD, DSD_OP_POINTER_STORE: begin
                            if (req_ptr_mode == DSD_MODE_PREDEC) begin
                                a = cur_ptr - 16'h0001;
                                p = a;
                            end else if (req_ptr_mode == DSD_MODE_POSTINC) begin
                                a = cur_ptr;
                                p = cur_ptr + 16'h0001;
                            end else begin
                                a = cur_ptr;
                                p = cur_ptr;
                            end
                            case (req_ptr_sel)
                                DSD_PTR_X: s_nxt.x = p;
                                DSD_PTR_Y: s_nxt.y = p;
                                DSD_PTR_Z: s_nxt.z = p;
                                default: s_nxt.x = p;
                            endcase
                        end
                        default: begin
                            // bit operations: upper half of i/o space is refused
                            ok = (req_addr[5:0] <= DSD_BITIO_LAST);
                            a = ok ? {10'h000, req_addr[5:0]} : DSD_FLASH_LAST + 16'h0001;
                            s_nxt.wmask = 8'h01 << req_bit;
                            s_nxt.wdata = (req_op == DSD_OP_IO_BIT_SET) ?
                                (8'h01 << req_bit) : 8'h00;
                        end
                    endcase
                    s_nxt.addr = a;
                end
            end
            DSD_ST_EXEC: begin
                // second cycle of the access: data is captured here
                if (in_io) begin
                    rd = io_rdata;
                end else if (in_sram) begin
                    rd = sram_rdata;
                end else if (in_lock) begin
                    rd = lock_bits;
                end else if (in_flash) begin
                    rd = s_r.addr[0] ? flash_word[15:8] : flash_word[7:0];
                end else begin
                    rd = 8'h00;
                end
                s_nxt.st = DSD_ST_IDLE;
                s_nxt.ack = 1'b1;
                s_nxt.rdata = is_write ? s_r.rdata : rd;
                s_nxt.skip = ((s_r.op == DSD_OP_SKIP_IF_SET) && rd[s_r.bitn]) ||
                    ((s_r.op == DSD_OP_SKIP_IF_CLEAR) && in_io && !rd[s_r.bitn]);
            end
            default: s_nxt.st = DSD_ST_IDLE;
        endcase
        // fetch pointer wraps within the 1024-word store
        if (fetch_jump) begin
            s_nxt.pwp = fetch_target;
        end else if (fetch_step) begin
            s_nxt.pwp = s_r.pwp + 10'h001;
        end
        s_nxt.instr = fetch_word;
    end

    // everything advances only on core clock edges; a stopped clock freezes it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= RESET_S;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign req_ready = (s_r.st == DSD_ST_IDLE);
    assign ack = s_r.ack;
    assign rdata = s_r.rdata;
    assign skip = s_r.skip;
    assign ptr_x = s_r.x;
    assign ptr_y = s_r.y;
    assign ptr_z = s_r.z;
    assign program_word_pointer = s_r.pwp;
    assign instr_word = s_r.instr;

    logic take;
    assign take = req_valid && req_ready;

    a_access_two_cycles: assert property (@(posedge clk) disable iff (rst)
        take |=> !ack ##1 ack)
        else $error("access did not answer in two cycles");
    // the byte must also be readable back once the write edge has passed
    a_sram_write_range: assert property (@(posedge clk) disable iff (rst)
        sram_we |-> ((s_r.addr >= 16'h0040) && (s_r.addr <= 16'h00BF))
        ##1 (sram_rdata == $past(s_r.wdata)))
        else $error("sram write outside its window or lost");
    a_flash_no_write: assert property (@(posedge clk) disable iff (rst)
        (exec && (in_flash || in_lock)) |-> !sram_we && !io_wr)
        else $error("write strobe into read-only region");
    a_direct_outside: assert property (@(posedge clk) disable iff (rst)
        (take && (req_op == DSD_OP_DIRECT_LOAD) && (req_addr < 16'h0040))
        |=> !io_rd ##1 (ack && rdata == 8'h00))
        else $error("direct load reached outside sram");
    a_predec_ptr: assert property (@(posedge clk) disable iff (rst)
        (take && !ptr_wr_en && (req_op == DSD_OP_POINTER_LOAD) &&
        (req_ptr_mode == DSD_MODE_PREDEC))
        |=> s_r.addr == $past(cur_ptr) - 16'h0001)
        else $error("pre-decrement address wrong");
    a_postinc_ptr: assert property (@(posedge clk) disable iff (rst)
        (take && !ptr_wr_en && (req_op == DSD_OP_POINTER_STORE) &&
        (req_ptr_mode == DSD_MODE_POSTINC) && (req_ptr_sel == DSD_PTR_Z))
        |=> (s_r.addr == $past(cur_ptr)) && (ptr_z == $past(cur_ptr) + 16'h0001))
        else $error("post-increment pointer wrong");
    a_bitop_one_bit: assert property (@(posedge clk) disable iff (rst)
        (io_wr && is_bitop) |-> $onehot(io_wmask) && (io_addr <= 6'h1F))
        else $error("bit operation touches more than one bit");
    a_bitop_upper_refused: assert property (@(posedge clk) disable iff (rst)
        (take && (req_op == DSD_OP_IO_BIT_SET) && req_addr[5]) |=> !io_wr && !io_rd)
        else $error("bit operation reached upper i/o half");
    a_pwp_step: assert property (@(posedge clk) disable iff (rst)
        (fetch_step && !fetch_jump)
        |=> program_word_pointer == $past(program_word_pointer) + 10'h001)
        else $error("program word pointer did not advance");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
        (exec && !is_write && !in_io && !in_sram && !in_lock && !in_flash) |=> rdata == 8'h00)
        else $error("unmapped read returned nonzero");

    c_sram_store: cover property (@(posedge clk) disable iff (rst) sram_we);
    c_flash_read: cover property (@(posedge clk) disable iff (rst) exec && in_flash && !is_write);
    c_bit_set: cover property (@(posedge clk) disable iff (rst) io_wr && is_bitop);
    c_back_to_back: cover property (@(posedge clk) disable iff (rst) take ##2 take);
endmodule
`default_nettype wire

/* File: core/dsd_pkg.sv */
// shared constants and types of the data-space address decoder
package dsd_pkg;
    localparam int DSD_ADDR_W = 16;
    localparam int DSD_DATA_W = 8;
    localparam int DSD_PROG_WORDS = 1024;
    localparam int DSD_PROG_W = 16;
    localparam int DSD_PWP_W = 10;
    localparam int DSD_SRAM_DEPTH = 128;
    localparam int DSD_SRAM_AW = 7;
    localparam logic [9:0] DSD_PWP_RESET = 10'h000;
    localparam logic [15:0] DSD_IO_LAST = 16'h003F;
    localparam logic [15:0] DSD_SRAM_BASE = 16'h0040;
    localparam logic [15:0] DSD_SRAM_LAST = 16'h00BF;
    localparam logic [15:0] DSD_LOCK_ADDR = 16'h3F00;
    localparam logic [15:0] DSD_FLASH_BASE = 16'h4000;
    localparam logic [15:0] DSD_FLASH_LAST = 16'h47FF;
    localparam logic [5:0] DSD_BITIO_LAST = 6'h1F;
    localparam logic [15:0] DSD_PTR_RESET = 16'h0000;

    typedef enum logic [3:0] {
        DSD_OP_IO_IN = 4'h0,
        DSD_OP_IO_OUT = 4'h1,
        DSD_OP_DIRECT_LOAD = 4'h2,
        DSD_OP_DIRECT_STORE = 4'h3,
        DSD_OP_POINTER_LOAD = 4'h4,
        DSD_OP_POINTER_STORE = 4'h5,
        DSD_OP_IO_BIT_SET = 4'h6,
        DSD_OP_IO_BIT_CLEAR = 4'h7,
        DSD_OP_SKIP_IF_SET = 4'h8,
        DSD_OP_SKIP_IF_CLEAR = 4'h9
    } dsd_op_e;

    typedef enum logic [1:0] {
        DSD_PTR_X = 2'h0,
        DSD_PTR_Y = 2'h1,
        DSD_PTR_Z = 2'h2
    } dsd_ptr_e;

    typedef enum logic [1:0] {
        DSD_MODE_PLAIN = 2'h0,
        DSD_MODE_POSTINC = 2'h1,
        DSD_MODE_PREDEC = 2'h2
    } dsd_mode_e;

    typedef enum logic [1:0] {
        DSD_ST_IDLE = 2'b01,
        DSD_ST_EXEC = 2'b10
    } dsd_state_e;
endpackage

/* File: core/dsd_sram.sv */
// internal data sram, flip-flop storage with combinational read
`timescale 1ns/1ps
`default_nettype none
module dsd_sram #(
    parameter int DEPTH = 128,
    parameter int AW = 7,
    parameter int DW = 8
) (
    // clock
    input wire logic clk,
    // access port
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
    } dsd_sram_s;

    dsd_sram_s s_r;
    dsd_sram_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (we) begin
            s_nxt.mem[addr] = wdata;
        end
    end

    // contents are undefined after power-up, so no reset
    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    assign rdata = s_r.mem[addr];
endmodule
`default_nettype wire

/* File: core/dsd_prog_flash.sv */
// program flash image: written only by the external programming path
`timescale 1ns/1ps
`default_nettype none
module dsd_prog_flash #(
    parameter int WORDS = 1024,
    parameter int AW = 10,
    parameter int DW = 16
) (
    // clock
    input wire logic clk,
    // external programming path
    input wire logic ext_prog_en,
    input wire logic [AW-1:0] ext_prog_addr,
    input wire logic [DW-1:0] ext_prog_data,
    // instruction fetch read
    input wire logic [AW-1:0] fetch_addr,
    output logic [DW-1:0] fetch_data,
    // data-space read
    input wire logic [AW-1:0] data_addr,
    output logic [DW-1:0] data_word
);
    typedef struct packed {
        logic [WORDS-1:0][DW-1:0] mem;
    } dsd_flash_s;

    dsd_flash_s s_r;
    dsd_flash_s s_nxt;

    // no core-side write port exists at all
    always_comb begin
        s_nxt = s_r;
        if (ext_prog_en) begin
            s_nxt.mem[ext_prog_addr] = ext_prog_data;
        end
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    assign fetch_data = s_r.mem[fetch_addr];
    assign data_word = s_r.mem[data_addr];
endmodule
`default_nettype wire

/* File: verif/dsd_io_model.sv */
// i/o peripheral register model that answers the decoder's i/o strobes
`timescale 1ns/1ps
`default_nettype none
module dsd_io_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // i/o strobes from the decoder
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_wmask,
    // read data back to the decoder
    output logic [7:0] io_rdata
);
    // every i/o location is backed here, so the bench never writes a reserved address
    logic [7:0] regs [0:63];
    logic [7:0] churn_r;
    // outside a read strobe the bus churns, so a late sample never matches by luck
    assign io_rdata = io_rd ? regs[io_addr] : churn_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            churn_r <= 8'h00;
            for (int i = 0; i < 64; i++) regs[i] <= 8'hC3 ^ 8'(i);
        end else begin
            churn_r <= churn_r + 8'h35;
            if (io_wr) begin
                regs[io_addr] <= (regs[io_addr] & ~io_wmask) | (io_wdata & io_wmask);
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/data_space_address_decoder_tb.sv */
// self-checking bench for the data-space address decoder
`timescale 1ns/1ps
`default_nettype none
module data_space_address_decoder_tb;
    import dsd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    dsd_op_e req_op = DSD_OP_IO_IN;
    logic [15:0] req_addr = 16'h0000;
    dsd_ptr_e req_ptr_sel = DSD_PTR_X;
    dsd_mode_e req_ptr_mode = DSD_MODE_PLAIN;
    logic [2:0] req_bit = 3'h0;
    logic [7:0] req_wdata = 8'h00;
    logic ptr_wr_en = 1'b0;
    dsd_ptr_e ptr_wr_sel = DSD_PTR_X;
    logic [15:0] ptr_wr_data = 16'h0000;
    logic [7:0] lock_bits = 8'h00;
    logic fetch_step = 1'b0;
    logic fetch_jump = 1'b0;
    logic [9:0] fetch_target = 10'h000;
    logic ext_prog_en = 1'b0;
    logic [9:0] ext_prog_addr = 10'h000;
    logic [15:0] ext_prog_data = 16'h0000;
    logic req_ready, ack, skip, io_rd, io_wr, sv_rd, sv_wr;
    logic [7:0] rdata, io_wdata, io_wmask, io_rdata, sv_mask, d;
    logic [15:0] ptr_x, ptr_y, ptr_z, instr_word, a, p;
    logic [5:0] io_addr, sv_addr, a6;
    logic [9:0] program_word_pointer;
    logic [2:0] b;
    logic [7:0] sr [0:127];
    logic [7:0] iom [0:63];
    logic [15:0] fl [0:1023];
    logic [15:0] dref [4] = '{16'h0010, 16'h00C0, 16'h3F00, 16'h4000};
    logic [15:0] ro [7] = '{16'h4001, 16'h3F00, 16'h00C0, 16'h1234, 16'h3F01, 16'h4800, 16'hFFFF};
    int fail_count = 0;
    int n_tests = 0;
    int seed = 32'hcbde7115;

    dsd_top dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_op(req_op), .req_addr(req_addr), .req_ptr_sel(req_ptr_sel),
        .req_ptr_mode(req_ptr_mode), .req_bit(req_bit), .req_wdata(req_wdata), .ack(ack),
        .rdata(rdata), .skip(skip), .ptr_wr_en(ptr_wr_en), .ptr_wr_sel(ptr_wr_sel),
        .ptr_wr_data(ptr_wr_data), .ptr_x(ptr_x), .ptr_y(ptr_y), .ptr_z(ptr_z),
        .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wmask(io_wmask), .io_rdata(io_rdata), .lock_bits(lock_bits),
        .fetch_step(fetch_step), .fetch_jump(fetch_jump), .fetch_target(fetch_target),
        .program_word_pointer(program_word_pointer), .instr_word(instr_word),
        .ext_prog_en(ext_prog_en), .ext_prog_addr(ext_prog_addr), .ext_prog_data(ext_prog_data));
    dsd_io_model io_u (.clk(clk), .rst(rst), .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wmask(io_wmask), .io_rdata(io_rdata));

    always #5 clk = ~clk;

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tmo(input string nm);
        fail_count++;
        $display("[FAIL] %s expected handshake seen none", nm);
        conclude();
    endtask

    // expected load data from the bench's own image of every region
    function automatic logic [7:0] exp_rd(input logic [15:0] x);
        if (x <= DSD_IO_LAST) return iom[x[5:0]];
        if (x <= DSD_SRAM_LAST) return sr[7'(x - DSD_SRAM_BASE)];
        if (x == DSD_LOCK_ADDR) return lock_bits;
        if (x >= DSD_FLASH_BASE && x <= DSD_FLASH_LAST)
            return x[0] ? fl[x[10:1]][15:8] : fl[x[10:1]][7:0];
        return 8'h00;
    endfunction

    function automatic logic [15:0] ptrv(input int s);
        return (s == 0) ? ptr_x : (s == 1) ? ptr_y : ptr_z;
    endfunction

    // one access: held until taken, strobes sampled in the middle cycle, ack counted
    task automatic acc(input dsd_op_e op, input logic [15:0] x, input int ps, input int md,
            input logic [2:0] bt, input logic [7:0] wd);
        int n;
        n = 0;
        req_op = op;
        req_addr = x;
        req_ptr_sel = dsd_ptr_e'(ps);
        req_ptr_mode = dsd_mode_e'(md);
        req_bit = bt;
        req_wdata = wd;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) begin
            if (n == 8) tmo("req_ready");
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        sv_rd = io_rd;
        sv_wr = io_wr;
        sv_addr = io_addr;
        sv_mask = io_wmask;
        n = 1;
        while (ack !== 1'b1) begin
            if (n == 8) tmo("ack");
            @(negedge clk);
            n++;
        end
        chk("ack_latency", 16'(n), 16'h0002);
    endtask

    task automatic setp(input int s, input logic [15:0] v);
        ptr_wr_sel = dsd_ptr_e'(s);
        ptr_wr_data = v;
        ptr_wr_en = 1'b1;
        @(negedge clk);
        ptr_wr_en = 1'b0;
    endtask

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask

    initial begin
        for (int i = 0; i < 64; i++) iom[i] = 8'hC3 ^ 8'(i);
        lock_bits = 8'($random(seed));
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk("pwp_reset", 16'(program_word_pointer), 16'h0000);
        chk("ptr_reset", ptr_x, DSD_PTR_RESET);
        done("reset");
        for (int i = 0; i < 8; i++) begin
            a6 = (i == 0) ? 6'h00 : (i == 2) ? 6'h3F : 6'($random(seed));
            d = 8'($random(seed));
            setp(2, 16'(a6));
            if (i[0]) acc(DSD_OP_POINTER_STORE, 16'h0000, 2, 0, 3'h0, d);
            else acc(DSD_OP_IO_OUT, {10'h000, a6}, 0, 0, 3'h0, d);
            chk("io_wr", 16'(sv_wr), 16'h0001);
            chk("io_addr", 16'(sv_addr), 16'(a6));
            iom[a6] = d;
            if (i[0]) acc(DSD_OP_POINTER_LOAD, 16'h0000, 2, 0, 3'h0, 8'h00);
            else acc(DSD_OP_IO_IN, {10'h000, a6}, 0, 0, 3'h0, 8'h00);
            chk("io_read", 16'(rdata), 16'(d));
            chk("io_rd", 16'(sv_rd), 16'h0001);
        end
        done("io");
        for (int i = 0; i < 24; i++) begin
            a = (i == 0) ? DSD_SRAM_BASE : (i == 1) ? DSD_SRAM_LAST :
                16'h0040 + 16'($random(seed) & 127);
            d = 8'($random(seed));
            acc(DSD_OP_DIRECT_STORE, a, 0, 0, 3'h0, d);
            chk("sram_no_io", 16'(sv_wr), 16'h0000);
            sr[7'(a - DSD_SRAM_BASE)] = d;
            acc(DSD_OP_DIRECT_LOAD, a, 0, 0, 3'h0, 8'h00);
            chk("sram_read", 16'(rdata), 16'(exp_rd(a)));
        end
        for (int i = 0; i < 4; i++) begin
            acc(DSD_OP_DIRECT_STORE, dref[i], 0, 0, 3'h0, 8'hA5);
            chk("direct_st_out", 16'(sv_wr), 16'h0000);
            acc(DSD_OP_DIRECT_LOAD, dref[i], 0, 0, 3'h0, 8'h00);
            chk("direct_ld_out", 16'(rdata), 16'h0000);
        end
        done("sram");
        for (int i = 0; i < 8; i++) begin
            a6 = (i < 3) ? 6'h1F : 6'($random(seed) & 31);
            b = 3'($random(seed));
            acc(i[0] ? DSD_OP_IO_BIT_CLEAR : DSD_OP_IO_BIT_SET, {10'h000, a6}, 0, 0, b, 8'h00);
            chk("bit_mask", 16'(sv_mask), 16'(8'h01 << b));
            iom[a6] = i[0] ? iom[a6] & ~(8'h01 << b) : iom[a6] | (8'h01 << b);
            acc(DSD_OP_IO_IN, {10'h000, a6}, 0, 0, 3'h0, 8'h00);
            chk("bit_result", 16'(rdata), 16'(iom[a6]));
            acc(i[1] ? DSD_OP_SKIP_IF_CLEAR : DSD_OP_SKIP_IF_SET, {10'h000, a6}, 0, 0, b, 8'h00);
            chk("skip", 16'(skip), 16'(iom[a6][b] ^ i[1]));
        end
        acc(DSD_OP_IO_BIT_SET, 16'h0020, 0, 0, 3'h2, 8'h00);
        chk("bit_upper", 16'(sv_wr), 16'h0000);
        acc(DSD_OP_SKIP_IF_CLEAR, 16'h0020, 0, 0, 3'h2, 8'h00);
        chk("skip_upper", 16'(skip), 16'h0000);
        done("bit");
        for (int i = 0; i < 9; i++) begin
            p = 16'h0060 + 16'($random(seed) & 63);
            d = 8'($random(seed));
            a = (i % 3 == 2) ? p - 16'h0001 : p;
            setp(i / 3, p);
            acc(DSD_OP_POINTER_STORE, 16'h0000, i / 3, i % 3, 3'h0, d);
            sr[7'(a - DSD_SRAM_BASE)] = d;
            chk("ptr_after_st", ptrv(i / 3), (i % 3 == 1) ? p + 16'h0001 : a);
            setp(i / 3, p);
            acc(DSD_OP_POINTER_LOAD, 16'h0000, i / 3, i % 3, 3'h0, 8'h00);
            chk("ptr_load", 16'(rdata), 16'(d));
            chk("ptr_after_ld", ptrv(i / 3), (i % 3 == 1) ? p + 16'h0001 : a);
        end
        done("pointer");
        // enable stays up across the burst, one word per edge
        ext_prog_en = 1'b1;
        for (int i = 0; i < 4; i++) begin
            ext_prog_addr = (i == 3) ? 10'h3FF : 10'(i);
            ext_prog_data = 16'($random(seed));
            fl[ext_prog_addr] = ext_prog_data;
            @(negedge clk);
        end
        ext_prog_en = 1'b0;
        for (int i = 0; i < 8; i++) begin
            a = (i < 6) ? DSD_FLASH_BASE + 16'(i) : 16'h47FE + 16'(i - 6);
            setp(2, a);
            acc(DSD_OP_POINTER_LOAD, 16'h0000, 2, 0, 3'h0, 8'h00);
            chk("flash_byte", 16'(rdata), 16'(exp_rd(a)));
        end
        // stores into read-only and unmapped places must leave nothing behind
        for (int i = 0; i < 7; i++) begin
            setp(2, ro[i]);
            acc(DSD_OP_POINTER_STORE, 16'h0000, 2, 0, 3'h0, ~exp_rd(ro[i]));
            chk("ro_no_io", 16'(sv_wr), 16'h0000);
            setp(2, ro[i]);
            acc(DSD_OP_POINTER_LOAD, 16'h0000, 2, 0, 3'h0, 8'h00);
            chk("ro_read", 16'(rdata), 16'(exp_rd(ro[i])));
        end
        done("flash");
        fetch_target = 10'h3FF;
        fetch_jump = 1'b1;
        @(negedge clk);
        fetch_jump = 1'b0;
        chk("pwp_jump", 16'(program_word_pointer), 16'h03FF);
        @(negedge clk);
        chk("instr_last", instr_word, fl[1023]);
        fetch_step = 1'b1;
        @(negedge clk);
        fetch_step = 1'b0;
        chk("pwp_wrap", 16'(program_word_pointer), 16'h0000);
        @(negedge clk);
        chk("instr_first", instr_word, fl[0]);
        done("fetch");
        conclude();
    end
endmodule
`default_nettype wire
